// [bench/ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none

module ctrl_model
  import sram_port_pkg::*;
(
  input wire logic i_k_clk,                 // True timing phase
  input wire logic i_kb_clk,                // Complement timing phase
  input wire logic i_reset_n,               // Async reset, active low
  output logic o_load_n,                    // Command strobe
  output logic o_read_sel,                  // High read, low write
  output logic [ADDR_W-1:0] o_addr,         // Pair address
  output logic [WORD_W-1:0] o_dq,           // Write side of the bus
  input wire logic [WORD_W-1:0] i_dq,       // Resolved bus level
  input wire logic i_valid,                 // Read words flagged valid
  input wire logic i_echo                   // Echo strobe, true
);
  logic slot;

  initial begin
    o_load_n = 1'b1;
    o_read_sel = 1'b0;
    o_addr = '0;
    o_dq = '0;
  end

  // Mirror of the device slot: value after an edge is the next edge's slot
  always @(posedge i_k_clk or negedge i_reset_n) begin
    if (!i_reset_n) slot <= 1'b0;
    else slot <= ~slot;
  end

  // A bad request lands on the slot the device must ignore
  task automatic xfer(input bit rd, input bit bad,
    input logic [ADDR_W-1:0] a, input word_pair_type w,
    output word_pair_type r, output int lat, output bit shape_ok);
    r = '0;
    lat = 0;
    shape_ok = 1'b1;
    do begin
      @(posedge i_k_clk);
      #1;
    end while (slot !== (bad ? 1'b0 : 1'b1));
    o_load_n = 1'b0;
    o_read_sel = rd;
    o_addr = a;
    @(posedge i_k_clk);
    #1;
    o_load_n = 1'b1;
    o_addr = ~a;
    if (!rd) begin
      o_dq = w.first;
      @(posedge i_k_clk);
      #1;
      o_dq = w.second;
      @(posedge i_kb_clk);
      #1;
      o_dq = ~w.second;
    end else begin
      for (int i = 1; i <= 3; i++) begin
        @(posedge i_k_clk);
        #1;
        if (lat == 0 && i_valid === 1'b1) begin
          lat = i;
          r.first = i_dq;
          shape_ok = (i_echo === 1'b1);
          @(posedge i_kb_clk);
          #1;
          r.second = i_dq;
          shape_ok = shape_ok && i_echo === 1'b0 && i_valid === 1'b1;
        end
      end
    end
  endtask
endmodule

`default_nettype wire

// [bench/tb_ddr_two_word_burst_sram_port.sv]
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  err_count++; $display("BAD %0t got %h want %h", $time, a, b); end end

module tb_ddr_two_word_burst_sram_port;
  import sram_port_pkg::*;

  logic ref_clk, reset_n, k_clk, kb_clk, load_n, read_sel, lat_pin;
  logic oe_n, echo, echo_n, valid, lat2_mode, commit;
  logic [ADDR_W-1:0] addr;
  logic [WORD_W-1:0] ctrl_dq, dq_out, bus;
  logic [WORD_W-1:0] m0 [16];
  logic [WORD_W-1:0] m1 [16];
  bit known [16];
  int err_count, total_checks, commits, writes;
  logic [31:0] seed;

  assign kb_clk = ~k_clk;
  // Device wins the wire only while it enables its drivers
  assign bus = oe_n ? ctrl_dq : dq_out;

  ddr_two_word_burst_sram_port #(.ARRAY_ADDR_W(4)) i_dut (
    .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_k_clk(k_clk),
    .i_kb_clk(kb_clk), .i_load_n(load_n), .i_read_sel(read_sel),
    .i_addr(addr), .i_dq_in(bus), .o_dq_out(dq_out), .o_dq_oe_n(oe_n),
    .o_echo_strobe_out(echo), .o_echo_strobe_out_n(echo_n),
    .o_output_valid_flag(valid), .i_latency_select_pin(lat_pin),
    .o_lat2_mode(lat2_mode), .o_write_commit(commit));

  ctrl_model i_ctrl (
    .i_k_clk(k_clk), .i_kb_clk(kb_clk), .i_reset_n(reset_n),
    .o_load_n(load_n), .o_read_sel(read_sel), .o_addr(addr),
    .o_dq(ctrl_dq), .i_dq(bus), .i_valid(valid), .i_echo(echo));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial begin
    k_clk = 1'b0;
    #1.3;
    forever #3 k_clk = ~k_clk;
  end

  // Sampled away from the launching edge of the pulse
  always @(negedge ref_clk) begin
    if (commit === 1'b1) commits++;
  end

  initial begin
    #20000;
    err_count++;
    wrap_up();
  end

  initial begin
    word_pair_type w, r;
    logic [2*WORD_W-1:0] raw;
    logic [3:0] a;
    bit rd, bad, ok;
    int lat;
    reset_n = 1'b0;
    lat_pin = 1'b1;
    seed = 32'hF93A76FC;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk) reset_n = 1'b1;
    repeat (4) @(posedge k_clk);
    for (int p = 0; p < 2; p++) begin
      @(negedge ref_clk) lat_pin = (p == 0);
      repeat (8) @(posedge ref_clk);
      `CHK(lat2_mode, lat_pin)
      for (int i = 0; i < 14; i++) begin
        seed = lfsr(seed);
        a = seed[3:0];
        rd = known[a] && seed[4];
        bad = (seed[6:5] == 2'b00);
        raw = (2*WORD_W)'({seed, ~lfsr(seed), seed});
        w = raw;
        i_ctrl.xfer(rd, bad, ADDR_W'(a), w, r, lat, ok);
        `CHK(echo_n, ~echo)
        if (bad) begin
          `CHK(lat, 0)
        end else if (rd) begin
          `CHK(lat, (p == 0) ? 2 : 1)
          `CHK(ok, 1'b1)
          `CHK(r.first, m0[a])
          `CHK(r.second, m1[a])
        end else begin
          m0[a] = w.first;
          m1[a] = w.second;
          known[a] = 1'b1;
          writes++;
          // Let the commit toggle settle into the reference domain
          repeat (3) @(posedge ref_clk);
        end
      end
    end
    repeat (20) @(posedge ref_clk);
    `CHK(commits, writes)
    wrap_up();
  end
endmodule

`default_nettype wire

// [rtl/ddr_two_word_burst_sram_port.sv]
// Functional notes
// - Address taken on alternate true-phase rising edges
// - Write words taken on both phase edges
// - Read words launched on true, then complement
// - Each address holds two sequential burst words
// - Select high: first read word after 2.0
// - Select low: read latency of one cycle
// - Valid flag high while read words driven
// - Free-running echo strobe aligned with data
// - Shared bus driven only during read bursts
// - Inputs and outputs pass phase-clocked registers
// - Array write self-timed, no extra strobes
// - Only rising edges of both phases used
// - Storage 2M x 18 or 1M x 36
`timescale 1ns/1ps
`default_nettype none

module ddr_two_word_burst_sram_port
  import sram_port_pkg::*;
#(
  parameter int ARRAY_ADDR_W = ADDR_W
) (
  input wire logic i_ref_clk,                 // System clock, 40 MHz
  input wire logic i_reset_n,                 // Async reset, active low
  input wire logic i_k_clk,                   // Timing clock, true phase
  input wire logic i_kb_clk,                  // Timing clock, complement
  input wire logic i_load_n,                  // Command strobe, low active
  input wire logic i_read_sel,                // High read, low write
  input wire logic [ADDR_W-1:0] i_addr,       // Burst pair address
  input wire logic [WORD_W-1:0] i_dq_in,      // Shared bus, input side
  output logic [WORD_W-1:0] o_dq_out,         // Shared bus, output side
  output logic o_dq_oe_n,                     // Bus enable, low drives
  output logic o_echo_strobe_out,             // Echo strobe, true
  output logic o_echo_strobe_out_n,           // Echo strobe, complement
  output logic o_output_valid_flag,           // Read words on the bus
  input wire logic i_latency_select_pin,      // High 2.0, low 1 cycle
  output logic o_lat2_mode,                   // Latency mode, ref domain
  output logic o_write_commit                 // Pulse per array write
);

  // Command decode: only the accepting slot of the pair of edges counts
  function automatic logic take_cmd(input logic slot, input logic load_n);
    take_cmd = (slot == ACCEPT_SLOT) && !load_n;
  endfunction

  logic lat_meta;
  logic lat_sync;
  logic lat2;
  logic slot;
  cmd_type cmd;
  logic pend_rd;
  word_pair_type pend_pair;
  word_pair_type rd_pair;
  logic next_launch;
  word_pair_type next_pair;
  logic drv_first;
  logic [WORD_W-1:0] q_first;
  logic hand_valid;
  logic [WORD_W-1:0] hand_second;
  logic wr_go;
  logic [ADDR_W-1:0] wr_addr;
  logic [WORD_W-1:0] wr_first;
  logic [WORD_W-1:0] kb_word;
  logic drv_second;
  logic [WORD_W-1:0] q_second;
  logic tog_k;
  logic tog_kb;
  logic sel_first;
  logic mem_we;
  word_pair_type mem_wdata;
  logic wr_tog;
  logic mode_meta;
  logic mode_sync;
  logic ev_meta;
  logic ev_sync;
  logic ev_last;

  // Latency pin is static but asynchronous to the timing pair
  always_ff @(posedge i_k_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lat_meta <= 1'b0;
      lat_sync <= 1'b0;
    end else begin
      lat_meta <= i_latency_select_pin;
      lat_sync <= lat_meta;
    end
  end

  assign lat2 = (lat_sync == LAT2_LEVEL);

  // Slot alternates each true-phase edge; falling edges never used
  always_ff @(posedge i_k_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      slot <= 1'b0;
    end else begin
      slot <= ~slot;
    end
  end

  // Command input register
  always_ff @(posedge i_k_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmd <= '0;
    end else begin
      cmd.valid <= take_cmd(slot, i_load_n);
      cmd.is_read <= (i_read_sel == READ_LEVEL);
      cmd.addr <= i_addr;
    end
  end

  pair_array #(
    .ARRAY_ADDR_W(ARRAY_ADDR_W)
  ) u_array (
    .i_k_clk(i_k_clk),
    .i_we(mem_we),
    .i_waddr(wr_addr[ARRAY_ADDR_W-1:0]),
    .i_wdata(mem_wdata),
    .i_raddr(cmd.addr[ARRAY_ADDR_W-1:0]),
    .o_rdata(rd_pair)
  );

  // Pair fetched one edge after capture, held for the 2.0-cycle path
  always_ff @(posedge i_k_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pend_rd <= 1'b0;
      pend_pair <= '0;
    end else begin
      pend_rd <= cmd.valid && cmd.is_read;
      pend_pair <= rd_pair;
    end
  end

  always_comb begin
    next_launch = lat2 ? pend_rd : (cmd.valid && cmd.is_read);
    next_pair = lat2 ? pend_pair : rd_pair;
  end

  // First word launched from the true-phase output register
  always_ff @(posedge i_k_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      drv_first <= 1'b0;
      q_first <= '0;
      hand_valid <= 1'b0;
      hand_second <= '0;
    end else begin
      drv_first <= next_launch;
      hand_valid <= next_launch;
      if (next_launch) begin
        q_first <= next_pair.first;
        hand_second <= next_pair.second;
      end
    end
  end

  // Write: first word at the edge after the address, second on complement
  always_ff @(posedge i_k_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_go <= 1'b0;
      wr_addr <= '0;
      wr_first <= '0;
    end else begin
      wr_go <= cmd.valid && !cmd.is_read;
      if (cmd.valid && !cmd.is_read) begin
        wr_addr <= cmd.addr;
        wr_first <= i_dq_in;
      end
    end
  end

  // Array write completes on its own at the following true edge
  assign mem_we = wr_go;
  assign mem_wdata = '{first: wr_first, second: kb_word};

  // Complement-phase registers; they sample the true-phase side, which is
  // the same timing pair with a fixed half-cycle offset, not a crossing
  always_ff @(posedge i_kb_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      kb_word <= '0;
      drv_second <= 1'b0;
      q_second <= '0;
      tog_kb <= 1'b0;
    end else begin
      kb_word <= i_dq_in;
      drv_second <= hand_valid;
      if (hand_valid) begin
        q_second <= hand_second;
      end
      tog_kb <= tog_k;
    end
  end

  always_ff @(posedge i_k_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tog_k <= 1'b0;
    end else begin
      tog_k <= ~tog_k;
    end
  end

  // High from a true edge to the next complement edge
  assign sel_first = tog_k ^ tog_kb;

  // Output mux picks whichever phase register launched last
  assign o_dq_out = sel_first ? q_first : q_second;
  assign o_dq_oe_n = ~(sel_first ? drv_first : drv_second);
  assign o_output_valid_flag = sel_first ? drv_first : drv_second;
  assign o_echo_strobe_out = sel_first;
  assign o_echo_strobe_out_n = ~sel_first;

  // Each array write flips a toggle for the reference domain
  always_ff @(posedge i_k_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_tog <= 1'b0;
    end else if (mem_we) begin
      wr_tog <= ~wr_tog;
    end
  end

  // Reference domain: level and toggle crossings
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_meta <= 1'b0;
      mode_sync <= 1'b0;
    end else begin
      mode_meta <= lat2;
      mode_sync <= mode_meta;
    end
  end

  assign o_lat2_mode = mode_sync;

  // Limitation: a write toggle must hold one reference period to be
  // seen; two writes closer together than that can cancel and lose both pulses
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ev_meta <= 1'b0;
      ev_sync <= 1'b0;
      ev_last <= 1'b0;
      o_write_commit <= 1'b0;
    end else begin
      ev_meta <= wr_tog;
      ev_sync <= ev_meta;
      ev_last <= ev_sync;
      o_write_commit <= ev_sync ^ ev_last;
    end
  end

  property p_alt_slot;
    @(posedge i_k_clk) disable iff (!i_reset_n)
      cmd.valid |-> ($past(slot) == ACCEPT_SLOT);
  endproperty
  a_alt_slot: assert property (p_alt_slot)
    else $error("command taken on the wrong slot");

  property p_read_lat2;
    @(posedge i_k_clk) disable iff (!i_reset_n)
      (cmd.valid && cmd.is_read && lat2 && $stable(lat2)) |=> ##1 drv_first;
  endproperty
  a_read_lat2: assert property (p_read_lat2)
    else $error("read word not launched two cycles after address");

  property p_read_lat1;
    @(posedge i_k_clk) disable iff (!i_reset_n)
      (cmd.valid && cmd.is_read && !lat2)
        |=> (drv_first && q_first == $past(rd_pair.first));
  endproperty
  a_read_lat1: assert property (p_read_lat1)
    else $error("read word not launched one cycle after address");

  property p_burst_pair;
    @(posedge i_k_clk) disable iff (!i_reset_n)
      (cmd.valid && cmd.is_read && !lat2)
        |=> (hand_second == $past(rd_pair.second));
  endproperty
  a_burst_pair: assert property (p_burst_pair)
    else $error("first word launched without its second word");

  property p_second_word;
    @(posedge i_kb_clk) disable iff (!i_reset_n)
      hand_valid |=> (drv_second && q_second == $past(hand_second));
  endproperty
  a_second_word: assert property (p_second_word)
    else $error("second read word not launched on complement edge");

  property p_drive_only_read;
    @(posedge i_k_clk) disable iff (!i_reset_n)
      drv_first |-> ($past(pend_rd) || $past(cmd.valid && cmd.is_read));
  endproperty
  a_drive_only_read: assert property (p_drive_only_read)
    else $error("bus driven outside a read burst");

  property p_write_commit;
    @(posedge i_k_clk) disable iff (!i_reset_n)
      (cmd.valid && !cmd.is_read) |=> (mem_we && wr_addr == $past(cmd.addr));
  endproperty
  a_write_commit: assert property (p_write_commit)
    else $error("captured write not committed to the array");

  property p_write_first;
    @(posedge i_k_clk) disable iff (!i_reset_n)
      (cmd.valid && !cmd.is_read) |=> (mem_wdata.first == $past(i_dq_in));
  endproperty
  a_write_first: assert property (p_write_first)
    else $error("first write word not taken at the true edge");

  property p_echo_runs;
    @(posedge i_k_clk) disable iff (!i_reset_n)
      $past(i_reset_n) |-> (tog_k != $past(tog_k));
  endproperty
  a_echo_runs: assert property (p_echo_runs)
    else $error("echo strobe stopped");

endmodule

`default_nettype wire

// [rtl/pair_array.sv]
`timescale 1ns/1ps
`default_nettype none

module pair_array
  import sram_port_pkg::*;
#(
  parameter int ARRAY_ADDR_W = ADDR_W
) (
  input wire logic i_k_clk,                       // True timing phase
  input wire logic i_we,                          // Commit a burst pair
  input wire logic [ARRAY_ADDR_W-1:0] i_waddr,    // Pair write index
  input wire word_pair_type i_wdata,              // Pair to store
  input wire logic [ARRAY_ADDR_W-1:0] i_raddr,    // Pair read index
  output word_pair_type o_rdata                   // Pair at read index
);

  // No reset: array contents are undefined until written
  word_pair_type store [2**ARRAY_ADDR_W];

  always_ff @(posedge i_k_clk) begin
    if (i_we) begin
      store[i_waddr] <= i_wdata;
    end
  end

  assign o_rdata = store[i_raddr];

endmodule

`default_nettype wire

// [rtl/sram_port_pkg.sv]
package sram_port_pkg;

  // Build option: 1 selects the 36-bit word build, 0 the 18-bit build
  localparam bit WIDE_BUILD = 1'b1;
  localparam int WORD_W_NARROW = 18;
  localparam int WORD_W_WIDE = 36;
  // Burst pair addresses: 2M x 18 and 1M x 36, two words per address
  localparam int ADDR_W_NARROW = 20;
  localparam int ADDR_W_WIDE = 19;
  localparam int WORD_W = WIDE_BUILD ? WORD_W_WIDE : WORD_W_NARROW;
  localparam int ADDR_W = WIDE_BUILD ? ADDR_W_WIDE : ADDR_W_NARROW;

  // Address slot phase on which a command is taken
  localparam logic ACCEPT_SLOT = 1'b1;
  // Level of the latency-select pin that picks the 2.0-cycle read latency
  localparam logic LAT2_LEVEL = 1'b1;
  // Level of the read/write select that marks a read
  localparam logic READ_LEVEL = 1'b1;

  typedef struct packed {
    logic valid;
    logic is_read;
    logic [ADDR_W-1:0] addr;
  } cmd_type;

  typedef struct packed {
    logic [WORD_W-1:0] first;
    logic [WORD_W-1:0] second;
  } word_pair_type;

endpackage
